// File: shared/cal_pkg.sv
package cal_pkg;
   // Datapath geometry
   localparam int DATA_W = 8;
   localparam int NREG = 32;
   localparam int SEL_W = 5;
   localparam int WORD_K_W = 6;
   localparam int NIB_W = 4;
   // Status flag positions
   localparam int FLAG_W = 6;
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   // Clocks per operation class
   localparam int CYC_BYTE_OP = 1;
   localparam int CYC_WORD_OP = 2;

   typedef logic [DATA_W-1:0] cal_byte_t;
   typedef logic [SEL_W-1:0] cal_sel_t;

   // Constant values
   localparam cal_byte_t MASK_ALL = 8'hff;
   localparam cal_byte_t ZERO_BYTE = 8'h00;
   localparam cal_byte_t REG_RST = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
   localparam cal_sel_t PAIR_STEP = 5'h01;

   // Operations accepted on the command port
   typedef enum logic [3:0] {
      OP_ADD,
      OP_ADD_WITH_CARRY,
      OP_WORD_ADD_IMMEDIATE,
      OP_SUBTRACT,
      OP_SUBTRACT_CONSTANT,
      OP_SUBTRACT_WITH_CARRY,
      OP_SUBTRACT_CARRY_CONSTANT,
      OP_WORD_SUBTRACT_IMMEDIATE,
      OP_AND,
      OP_AND_CONSTANT,
      OP_OR,
      OP_OR_CONSTANT,
      OP_EXCLUSIVE_OR,
      OP_BIT_SET_MASK,
      OP_BIT_CLEAR_MASK
   } cal_op_e;

   // Byte ALU functions
   typedef enum logic [2:0] {
      ALU_ADD,
      ALU_SUB,
      ALU_AND,
      ALU_OR,
      ALU_XOR
   } cal_alu_e;

   // Sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_WORD_HI
   } cal_state_e;
endpackage

// File: src/cal_regfile.sv
`timescale 1ns/10ps
module cal_regfile #(
   parameter int NREG = cal_pkg::NREG
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Write port
   input wire logic wr_en,
   input wire cal_pkg::cal_sel_t wr_sel,
   input wire cal_pkg::cal_byte_t wr_data,
   // Read ports
   input wire cal_pkg::cal_sel_t rd_a_sel,
   input wire cal_pkg::cal_sel_t rd_b_sel,
   input wire cal_pkg::cal_sel_t rd_c_sel,
   output cal_pkg::cal_byte_t rd_a,
   output cal_pkg::cal_byte_t rd_b,
   output cal_pkg::cal_byte_t rd_c
);
   cal_pkg::cal_byte_t mem_r [NREG];
   cal_pkg::cal_byte_t mem_nxt [NREG];

   // Reads are combinational so one op reads and writes in one clock
   assign rd_a = mem_r[rd_a_sel];
   assign rd_b = mem_r[rd_b_sel];
   assign rd_c = mem_r[rd_c_sel];

   // One write per clock; word ops spend two clocks for that reason
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (wr_en) begin
         mem_nxt[wr_sel] = wr_data;
      end
   end

   // Storage flip-flops, frozen while the clock enable is low
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < NREG; i++) begin
         if (sys_rst) begin
            mem_r[i] <= cal_pkg::REG_RST;
         end else if (clk_en) begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end
endmodule

// File: src/cal_alu8.sv
`timescale 1ns/10ps
module cal_alu8 (
   // Operands
   input wire cal_pkg::cal_byte_t a,
   input wire cal_pkg::cal_byte_t b,
   input wire logic cin,
   input wire cal_pkg::cal_alu_e kind,
   // Result and flags
   output cal_pkg::cal_byte_t r,
   output logic c,
   output logic z,
   output logic n,
   output logic v,
   output logic h
);
   localparam int MSB = cal_pkg::DATA_W - 1;
   logic [cal_pkg::DATA_W:0] wide;
   logic [cal_pkg::NIB_W:0] nib;

   // Extra top bit gives carry or borrow without separate equations
   always_comb begin
      wide = '0;
      nib = '0;
      r = cal_pkg::ZERO_BYTE;
      c = 1'b0;
      v = 1'b0;
      h = 1'b0;
      case (kind)
         cal_pkg::ALU_ADD: begin
            wide = {1'b0, a} + {1'b0, b} + {{cal_pkg::DATA_W{1'b0}}, cin};
            nib = {1'b0, a[cal_pkg::NIB_W-1:0]} + {1'b0, b[cal_pkg::NIB_W-1:0]}
                  + {{cal_pkg::NIB_W{1'b0}}, cin};
            r = wide[MSB:0];
            c = wide[cal_pkg::DATA_W];
            h = nib[cal_pkg::NIB_W];
            v = (a[MSB] == b[MSB]) && (r[MSB] != a[MSB]);
         end
         cal_pkg::ALU_SUB: begin
            // Carry here means borrow, as the branch logic expects
            wide = {1'b0, a} - {1'b0, b} - {{cal_pkg::DATA_W{1'b0}}, cin};
            nib = {1'b0, a[cal_pkg::NIB_W-1:0]} - {1'b0, b[cal_pkg::NIB_W-1:0]}
                  - {{cal_pkg::NIB_W{1'b0}}, cin};
            r = wide[MSB:0];
            c = wide[cal_pkg::DATA_W];
            h = nib[cal_pkg::NIB_W];
            v = (a[MSB] != b[MSB]) && (r[MSB] != a[MSB]);
         end
         cal_pkg::ALU_AND: r = a & b;
         cal_pkg::ALU_OR: r = a | b;
         cal_pkg::ALU_XOR: r = a ^ b;
         default: r = cal_pkg::ZERO_BYTE;
      endcase
      z = (r == cal_pkg::ZERO_BYTE);
      n = r[MSB];
   end
endmodule

// File: src/cal_core.sv
// Overview of operation
// - Add and add-carry: sum, five flags, 1 clock.
// - Word add immediate on pair, sign flag, 2 clocks.
// - Subtract register or constant, five flags, 1 clock.
// - Subtract register with carry, five flags, 1 clock.
// - Subtract constant with carry, five flags, 1 clock.
// - Word subtract immediate on pair, 2 clocks.
// - AND register or constant, Z N V, 1 clock.
// - OR and exclusive OR, Z N V, 1 clock.
// - Bit set ORs mask in, Z N V.
// - Bit clear ANDs inverted mask, Z N V.
`timescale 1ns/10ps
module cal_core #(
   parameter int NREG = cal_pkg::NREG
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Command
   input wire logic op_valid,
   input wire cal_pkg::cal_op_e op_code,
   input wire cal_pkg::cal_sel_t dst_sel,
   input wire cal_pkg::cal_sel_t source_register,
   input wire cal_pkg::cal_byte_t imm,
   // Register inspection
   input wire cal_pkg::cal_sel_t dbg_sel,
   output cal_pkg::cal_byte_t dbg_data_r,
   // Status
   output logic ready_r,
   output logic done_r,
   output cal_pkg::cal_byte_t result_r,
   output logic [cal_pkg::FLAG_W-1:0] flags_r
);
   cal_pkg::cal_state_e state_r, state_nxt;
   logic ready_nxt, done_nxt;
   logic wcarry_r, wcarry_nxt, wzero_r, wzero_nxt, wsub_r, wsub_nxt;
   cal_pkg::cal_sel_t hi_sel_r, hi_sel_nxt;
   cal_pkg::cal_byte_t result_nxt, dbg_data_nxt;
   logic [cal_pkg::FLAG_W-1:0] flags_nxt;
   logic take;
   cal_pkg::cal_sel_t rd_a_sel;
   cal_pkg::cal_byte_t rd_a, rd_b, rd_c;
   logic wr_en;
   cal_pkg::cal_sel_t wr_sel;
   cal_pkg::cal_byte_t alu_a, alu_b, alu_r;
   logic alu_cin, alu_c, alu_z, alu_n, alu_v, alu_h;
   cal_pkg::cal_alu_e alu_kind;

   // A command is taken only when idle and enabled
   assign take = clk_en && op_valid && ready_r;

   // Second word cycle reads the high register of the pair
   assign rd_a_sel = (state_r == cal_pkg::ST_WORD_HI) ? hi_sel_r : dst_sel;

   cal_regfile #(
      .NREG(NREG)
   ) u_regs (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .wr_en(wr_en),
      .wr_sel(wr_sel),
      .wr_data(alu_r),
      .rd_a_sel(rd_a_sel),
      .rd_b_sel(source_register),
      .rd_c_sel(dbg_sel),
      .rd_a(rd_a),
      .rd_b(rd_b),
      .rd_c(rd_c)
   );

   cal_alu8 u_alu (
      .a(alu_a),
      .b(alu_b),
      .cin(alu_cin),
      .kind(alu_kind),
      .r(alu_r),
      .c(alu_c),
      .z(alu_z),
      .n(alu_n),
      .v(alu_v),
      .h(alu_h)
   );

   // Operand selection and ALU function for each operation
   always_comb begin
      alu_a = rd_a;
      alu_b = rd_b;
      alu_cin = 1'b0;
      alu_kind = cal_pkg::ALU_ADD;
      if (state_r == cal_pkg::ST_WORD_HI) begin
         alu_b = cal_pkg::ZERO_BYTE;
         alu_cin = wcarry_r;
         alu_kind = wsub_r ? cal_pkg::ALU_SUB : cal_pkg::ALU_ADD;
      end else begin
         case (op_code)
            cal_pkg::OP_ADD_WITH_CARRY: alu_cin = flags_r[cal_pkg::FLG_C];
            cal_pkg::OP_WORD_ADD_IMMEDIATE: begin
               alu_b = {{(cal_pkg::DATA_W - cal_pkg::WORD_K_W){1'b0}},
                        imm[cal_pkg::WORD_K_W-1:0]};
            end
            cal_pkg::OP_SUBTRACT: alu_kind = cal_pkg::ALU_SUB;
            cal_pkg::OP_SUBTRACT_CONSTANT: begin
               alu_b = imm;
               alu_kind = cal_pkg::ALU_SUB;
            end
            cal_pkg::OP_SUBTRACT_WITH_CARRY: begin
               alu_cin = flags_r[cal_pkg::FLG_C];
               alu_kind = cal_pkg::ALU_SUB;
            end
            cal_pkg::OP_SUBTRACT_CARRY_CONSTANT: begin
               alu_b = imm;
               alu_cin = flags_r[cal_pkg::FLG_C];
               alu_kind = cal_pkg::ALU_SUB;
            end
            cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE: begin
               alu_b = {{(cal_pkg::DATA_W - cal_pkg::WORD_K_W){1'b0}},
                        imm[cal_pkg::WORD_K_W-1:0]};
               alu_kind = cal_pkg::ALU_SUB;
            end
            cal_pkg::OP_AND: alu_kind = cal_pkg::ALU_AND;
            cal_pkg::OP_AND_CONSTANT: begin
               alu_b = imm;
               alu_kind = cal_pkg::ALU_AND;
            end
            cal_pkg::OP_OR: alu_kind = cal_pkg::ALU_OR;
            cal_pkg::OP_OR_CONSTANT: begin
               alu_b = imm;
               alu_kind = cal_pkg::ALU_OR;
            end
            cal_pkg::OP_EXCLUSIVE_OR: alu_kind = cal_pkg::ALU_XOR;
            cal_pkg::OP_BIT_SET_MASK: begin
               alu_b = imm;
               alu_kind = cal_pkg::ALU_OR;
            end
            cal_pkg::OP_BIT_CLEAR_MASK: begin
               alu_b = cal_pkg::MASK_ALL - imm;
               alu_kind = cal_pkg::ALU_AND;
            end
            default: alu_kind = cal_pkg::ALU_ADD;
         endcase
      end
   end

   // Sequencer, write strobe and flag update
   always_comb begin
      state_nxt = state_r;
      ready_nxt = ready_r;
      done_nxt = 1'b0;
      wcarry_nxt = wcarry_r;
      wzero_nxt = wzero_r;
      wsub_nxt = wsub_r;
      hi_sel_nxt = hi_sel_r;
      result_nxt = result_r;
      flags_nxt = flags_r;
      dbg_data_nxt = rd_c;
      wr_en = 1'b0;
      wr_sel = dst_sel;
      case (state_r)
         cal_pkg::ST_IDLE: begin
            if (take) begin
               wr_en = 1'b1;
               result_nxt = alu_r;
               if (op_code == cal_pkg::OP_WORD_ADD_IMMEDIATE ||
                   op_code == cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE) begin
                  hi_sel_nxt = dst_sel + cal_pkg::PAIR_STEP;
                  wcarry_nxt = alu_c;
                  wzero_nxt = alu_z;
                  wsub_nxt = (op_code == cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE);
                  state_nxt = cal_pkg::ST_WORD_HI;
                  ready_nxt = 1'b0;
               end else begin
                  done_nxt = 1'b1;
                  flags_nxt[cal_pkg::FLG_Z] = alu_z;
                  flags_nxt[cal_pkg::FLG_N] = alu_n;
                  flags_nxt[cal_pkg::FLG_V] = alu_v;
                  if (alu_kind == cal_pkg::ALU_ADD || alu_kind == cal_pkg::ALU_SUB) begin
                     flags_nxt[cal_pkg::FLG_C] = alu_c;
                     flags_nxt[cal_pkg::FLG_H] = alu_h;
                  end
               end
            end
         end
         cal_pkg::ST_WORD_HI: begin
            if (clk_en) begin
               wr_en = 1'b1;
               wr_sel = hi_sel_r;
               result_nxt = alu_r;
               done_nxt = 1'b1;
               flags_nxt[cal_pkg::FLG_Z] = wzero_r && alu_z;
               flags_nxt[cal_pkg::FLG_C] = alu_c;
               flags_nxt[cal_pkg::FLG_N] = alu_n;
               flags_nxt[cal_pkg::FLG_V] = alu_v;
               flags_nxt[cal_pkg::FLG_S] = alu_n ^ alu_v;
               state_nxt = cal_pkg::ST_IDLE;
               ready_nxt = 1'b1;
            end
         end
         default: state_nxt = cal_pkg::ST_IDLE;
      endcase
   end

   // State registers; everything holds while the enable is low
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= cal_pkg::ST_IDLE;
         ready_r <= 1'b1;
         done_r <= 1'b0;
         wcarry_r <= 1'b0;
         wzero_r <= 1'b0;
         wsub_r <= 1'b0;
         hi_sel_r <= '0;
         result_r <= cal_pkg::ZERO_BYTE;
         flags_r <= cal_pkg::FLAGS_RST;
         dbg_data_r <= cal_pkg::ZERO_BYTE;
      end else if (clk_en) begin
         state_r <= state_nxt;
         ready_r <= ready_nxt;
         done_r <= done_nxt;
         wcarry_r <= wcarry_nxt;
         wzero_r <= wzero_nxt;
         wsub_r <= wsub_nxt;
         hi_sel_r <= hi_sel_nxt;
         result_r <= result_nxt;
         flags_r <= flags_nxt;
         dbg_data_r <= dbg_data_nxt;
      end
   end

   // Checks on the datapath
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   AST_ADD_SUM: assert property (
      take && op_code == cal_pkg::OP_ADD_WITH_CARRY |=> done_r &&
      result_r == cal_pkg::cal_byte_t'($past(rd_a) + $past(rd_b)
                  + $past(flags_r[cal_pkg::FLG_C])))
      else $error("add with carry result wrong");
   AST_WORD_ADD: assert property (
      (take && op_code == cal_pkg::OP_WORD_ADD_IMMEDIATE ##1 clk_en)
      |=> done_r && ready_r &&
      flags_r[cal_pkg::FLG_S] == (flags_r[cal_pkg::FLG_N] ^ flags_r[cal_pkg::FLG_V]))
      else $error("word add did not finish in two clocks");
   AST_SUB_CONST: assert property (
      take && op_code == cal_pkg::OP_SUBTRACT_CONSTANT |=>
      result_r == cal_pkg::cal_byte_t'($past(rd_a) - $past(imm)) &&
      flags_r[cal_pkg::FLG_C] == ($past(imm) > $past(rd_a)))
      else $error("subtract constant wrong");
   AST_SUB_CARRY: assert property (
      take && op_code == cal_pkg::OP_SUBTRACT_WITH_CARRY |=>
      result_r == cal_pkg::cal_byte_t'($past(rd_a) - $past(rd_b)
                  - $past(flags_r[cal_pkg::FLG_C])))
      else $error("subtract with carry wrong");
   AST_SUB_CARRY_CONST: assert property (
      take && op_code == cal_pkg::OP_SUBTRACT_CARRY_CONSTANT |=>
      result_r == cal_pkg::cal_byte_t'($past(rd_a) - $past(imm)
                  - $past(flags_r[cal_pkg::FLG_C])))
      else $error("subtract carry constant wrong");
   AST_WORD_SUB: assert property (
      take && op_code == cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE |=>
      !ready_r && !done_r && wsub_r)
      else $error("word subtract did not hold for its second clock");
   AST_AND_FLAGS: assert property (
      take && op_code == cal_pkg::OP_AND |=>
      result_r == ($past(rd_a) & $past(rd_b)) && !flags_r[cal_pkg::FLG_V] &&
      flags_r[cal_pkg::FLG_C] == $past(flags_r[cal_pkg::FLG_C]))
      else $error("and result or flags wrong");
   AST_XOR: assert property (
      take && op_code == cal_pkg::OP_EXCLUSIVE_OR |=>
      result_r == ($past(rd_a) ^ $past(rd_b)) &&
      flags_r[cal_pkg::FLG_Z] == (result_r == cal_pkg::ZERO_BYTE))
      else $error("exclusive or wrong");
   AST_SET_MASK: assert property (
      take && op_code == cal_pkg::OP_BIT_SET_MASK |=>
      result_r == ($past(rd_a) | $past(imm)))
      else $error("bit set wrong");
   AST_CLEAR_MASK: assert property (
      take && op_code == cal_pkg::OP_BIT_CLEAR_MASK |=>
      (result_r & $past(imm)) == cal_pkg::ZERO_BYTE &&
      result_r == ($past(rd_a) & ~$past(imm)))
      else $error("bit clear wrong");
   AST_PAIR_HIGH: assert property (
      take && op_code == cal_pkg::OP_WORD_ADD_IMMEDIATE |=>
      hi_sel_r == cal_pkg::cal_sel_t'($past(dst_sel) + cal_pkg::PAIR_STEP))
      else $error("high register of pair wrong");

   // Main scenarios
   COV_WORD_CARRY: cover property (
      take && op_code == cal_pkg::OP_WORD_ADD_IMMEDIATE ##1 wcarry_r);
   COV_SUB_BORROW: cover property (
      take && op_code == cal_pkg::OP_SUBTRACT ##1 flags_r[cal_pkg::FLG_C]);
   COV_BACK_TO_BACK: cover property (take ##1 take);
endmodule

// File: sim/cal_core_bench.sv
`timescale 1ns/10ps
module cal_core_bench;
   logic clk_sys;
   logic sys_rst;
   logic clk_en;
   logic op_valid;
   cal_pkg::cal_op_e op_code;
   cal_pkg::cal_sel_t dst_sel;
   cal_pkg::cal_sel_t source_register;
   cal_pkg::cal_byte_t imm;
   cal_pkg::cal_sel_t dbg_sel;
   cal_pkg::cal_byte_t dbg_data_r;
   logic ready_r;
   logic done_r;
   cal_pkg::cal_byte_t result_r;
   logic [cal_pkg::FLAG_W-1:0] flags_r;
   int failures;
   int n_checks;
   int cyc = 0;
   logic [7:0] sh [32];
   logic [5:0] shf;

   cal_core #(.NREG(32)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .op_valid(op_valid),
      .op_code(op_code), .dst_sel(dst_sel), .source_register(source_register), .imm(imm),
      .dbg_sel(dbg_sel), .dbg_data_r(dbg_data_r), .ready_r(ready_r), .done_r(done_r),
      .result_r(result_r), .flags_r(flags_r)
   );

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard; the whole run needs under a hundred cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Inspection port lags one edge, so two edges are allowed
   task automatic read_reg(input int sel, input logic [7:0] exp);
      dbg_sel = sel[4:0];
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk({8'h00, dbg_data_r}, {8'h00, exp});
   endtask

   // Drives one command from a falling edge, predicts and judges it
   task automatic run_op(input cal_pkg::cal_op_e op, input int d, input int s,
                         input logic [7:0] k, input int stall, input bit poke);
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] r;
      logic [8:0] w9;
      logic [4:0] w5;
      logic [16:0] w17;
      logic [15:0] pa;
      logic [5:0] f;
      logic ci;
      int cls;
      int dh;
      dh = (d + 1) % 32;
      a = sh[d];
      b = sh[s];
      f = shf;
      ci = 1'b0;
      cls = 2;
      r = 8'h00;
      case (op)
         cal_pkg::OP_ADD: cls = 0;
         cal_pkg::OP_ADD_WITH_CARRY: begin cls = 0; ci = shf[0]; end
         cal_pkg::OP_SUBTRACT: cls = 1;
         cal_pkg::OP_SUBTRACT_CONSTANT: begin cls = 1; b = k; end
         cal_pkg::OP_SUBTRACT_WITH_CARRY: begin cls = 1; ci = shf[0]; end
         cal_pkg::OP_SUBTRACT_CARRY_CONSTANT: begin cls = 1; b = k; ci = shf[0]; end
         cal_pkg::OP_AND: r = a & b;
         cal_pkg::OP_AND_CONSTANT: r = a & k;
         cal_pkg::OP_OR: r = a | b;
         cal_pkg::OP_OR_CONSTANT: r = a | k;
         cal_pkg::OP_EXCLUSIVE_OR: r = a ^ b;
         cal_pkg::OP_BIT_SET_MASK: r = a | k;
         cal_pkg::OP_BIT_CLEAR_MASK: r = a & (8'hff - k);
         cal_pkg::OP_WORD_ADD_IMMEDIATE: cls = 3;
         default: cls = 4;
      endcase
      if (cls == 0) begin
         w9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         w5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
         r = w9[7:0];
         f[0] = w9[8];
         f[5] = w5[4];
         f[3] = (a[7] == b[7]) && (r[7] != a[7]);
      end else if (cls == 1) begin
         w9 = {1'b0, a} - {1'b0, b} - {8'h00, ci};
         w5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
         r = w9[7:0];
         f[0] = w9[8];
         f[5] = w5[4];
         f[3] = (a[7] != b[7]) && (r[7] != a[7]);
      end else if (cls == 2) begin
         f[3] = 1'b0;
      end
      if (cls < 3) begin
         f[1] = (r == 8'h00);
         f[2] = r[7];
         sh[d] = r;
      end else begin
         pa = {sh[dh], a};
         if (cls == 3) w17 = {1'b0, pa} + {11'h000, k[5:0]};
         else w17 = {1'b0, pa} - {11'h000, k[5:0]};
         f[0] = w17[16];
         f[1] = (w17[15:0] == 16'h0000);
         f[2] = w17[15];
         f[3] = (cls == 3) ? (!pa[15] && w17[15]) : (pa[15] && !w17[15]);
         f[4] = f[2] ^ f[3];
         sh[d] = w17[7:0];
         sh[dh] = w17[15:8];
      end
      shf = f;
      chk({15'h0000, ready_r}, 16'h0001);
      op_valid = 1'b1;
      op_code = op;
      dst_sel = d[4:0];
      source_register = s[4:0];
      imm = k;
      repeat (stall) begin
         clk_en = 1'b0;
         @(negedge clk_sys);
      end
      clk_en = 1'b1;
      @(negedge clk_sys);
      op_valid = 1'b0;
      if (cls >= 3) begin
         chk({14'h0000, ready_r, done_r}, 16'h0000);
         chk({8'h00, result_r}, {8'h00, sh[d]});
         if (poke) begin
            op_valid = 1'b1;
            op_code = cal_pkg::OP_OR_CONSTANT;
            dst_sel = d[4:0] + 5'h02;
            imm = 8'hff;
         end
         // A frozen second cycle must stretch the op, not finish it
         repeat (stall) begin
            clk_en = 1'b0;
            @(negedge clk_sys);
            chk({14'h0000, ready_r, done_r}, 16'h0000);
         end
         clk_en = 1'b1;
         @(negedge clk_sys);
         op_valid = 1'b0;
         chk({8'h00, result_r}, {8'h00, sh[dh]});
      end else begin
         chk({8'h00, result_r}, {8'h00, r});
      end
      chk({14'h0000, ready_r, done_r}, 16'h0003);
      chk({10'h000, flags_r}, {10'h000, f});
   endtask

   // Quiet state after reset
   task automatic sc_reset;
      chk({14'h0000, ready_r, done_r}, 16'h0002);
      chk({2'h0, flags_r, result_r}, 16'h0000);
      read_reg(5, 8'h00);
   endtask

   // Logic family; carry set first must survive untouched
   task automatic sc_logic;
      run_op(cal_pkg::OP_OR_CONSTANT, 3, 0, 8'h80, 0, 0);
      run_op(cal_pkg::OP_ADD, 3, 3, 8'h00, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 1, 0, 8'ha5, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 2, 0, 8'h3c, 0, 0);
      run_op(cal_pkg::OP_AND, 1, 2, 8'h00, 0, 0);
      run_op(cal_pkg::OP_AND_CONSTANT, 2, 0, 8'hf0, 0, 0);
      run_op(cal_pkg::OP_OR, 1, 2, 8'h00, 0, 0);
      run_op(cal_pkg::OP_EXCLUSIVE_OR, 1, 1, 8'h00, 0, 0);
      run_op(cal_pkg::OP_BIT_SET_MASK, 1, 0, 8'h81, 0, 0);
      run_op(cal_pkg::OP_BIT_CLEAR_MASK, 1, 0, 8'h01, 0, 0);
      run_op(cal_pkg::OP_BIT_CLEAR_MASK, 2, 0, 8'hff, 0, 0);
      @(negedge clk_sys);
      chk({15'h0000, done_r}, 16'h0000);
      read_reg(1, 8'h80);
   endtask

   // Overflow, half carry and carry in
   task automatic sc_add;
      run_op(cal_pkg::OP_OR_CONSTANT, 4, 0, 8'h7f, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 5, 0, 8'h01, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 6, 0, 8'h0f, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 7, 0, 8'hff, 0, 0);
      run_op(cal_pkg::OP_ADD, 4, 5, 8'h00, 0, 0);
      run_op(cal_pkg::OP_ADD, 7, 5, 8'h00, 0, 0);
      run_op(cal_pkg::OP_ADD_WITH_CARRY, 6, 0, 8'h00, 0, 0);
      run_op(cal_pkg::OP_ADD_WITH_CARRY, 6, 6, 8'h00, 0, 0);
   endtask

   // Borrow chains through every byte subtract form
   task automatic sc_sub;
      run_op(cal_pkg::OP_SUBTRACT, 8, 5, 8'h00, 0, 0);
      run_op(cal_pkg::OP_SUBTRACT_WITH_CARRY, 8, 5, 8'h00, 0, 0);
      run_op(cal_pkg::OP_SUBTRACT_CONSTANT, 8, 0, 8'hfd, 0, 0);
      run_op(cal_pkg::OP_SUBTRACT_CARRY_CONSTANT, 8, 0, 8'h00, 0, 0);
      run_op(cal_pkg::OP_SUBTRACT_CONSTANT, 8, 0, 8'h01, 0, 0);
      run_op(cal_pkg::OP_SUBTRACT_CARRY_CONSTANT, 8, 0, 8'h7e, 0, 0);
   endtask

   // Pair arithmetic, refused poke in the second cycle, wrap at 31
   task automatic sc_word;
      run_op(cal_pkg::OP_OR_CONSTANT, 24, 0, 8'hff, 0, 0);
      run_op(cal_pkg::OP_OR_CONSTANT, 25, 0, 8'h7f, 0, 0);
      run_op(cal_pkg::OP_WORD_ADD_IMMEDIATE, 24, 0, 8'h01, 0, 1);
      read_reg(25, 8'h80);
      read_reg(26, 8'h00);
      run_op(cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 24, 0, 8'hff, 0, 0);
      run_op(cal_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 31, 0, 8'h01, 0, 0);
      read_reg(0, 8'hff);
      run_op(cal_pkg::OP_WORD_ADD_IMMEDIATE, 31, 0, 8'h01, 0, 0);
   endtask

   // A frozen clock must not let a self-add repeat
   task automatic sc_stall;
      run_op(cal_pkg::OP_OR_CONSTANT, 9, 0, 8'h11, 0, 0);
      run_op(cal_pkg::OP_ADD, 9, 9, 8'h00, 3, 0);
      read_reg(9, 8'h22);
      run_op(cal_pkg::OP_WORD_ADD_IMMEDIATE, 10, 0, 8'h03, 2, 1);
      read_reg(11, 8'h00);
      read_reg(12, 8'h00);
   endtask

   // Main sequence
   initial begin
      failures = 0;
      n_checks = 0;
      shf = 6'h00;
      for (int i = 0; i < 32; i++) sh[i] = 8'h00;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      op_valid = 1'b0;
      op_code = cal_pkg::OP_ADD;
      dst_sel = 5'h00;
      source_register = 5'h00;
      imm = 8'h00;
      dbg_sel = 5'h00;
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      sc_reset();
      sc_logic();
      sc_add();
      sc_sub();
      sc_word();
      sc_stall();
      report_and_stop();
   end
endmodule
